//--- tb.sv
`timescale 1ns/10ps
module tb;
  import vobw_pkg::*;
  logic              core_clk_in, rstn_in, pvci, cdec, req, req_rd, rsp_rdy, m_gnt, m_rdy, m_err, s_sel;
  logic              s_val, s_wr, b_wr, m_req, m_val, m_wr, busy, rsp_v, rsp_e, wr_stb, s_rdy;
  logic [VC_AW-1:0]  req_addr;
  logic [VC_BW-1:0]  req_be, s_be, m_be, b_be;
  logic [BUS_DW-1:0] req_wd, m_rd, s_wd, m_wd, s_rd, rsp_d, b_wd;
  logic [BUS_AW-1:0] s_addr, m_addr, b_addr;
  logic [TGT_AW-1:0] wr_a;
  logic [TGT_DW-1:0] wr_d;
  logic [15:0]       hi;
  logic [7:0]        offs [2] = '{8'h26, 8'h3c};
  int                cyc, xfer_cyc, wcnt, rwait, n_wr, n_mismatch, total_checks;
  vobw_vci_if vif ();
  vobw_bus_wrapper u_vobw_bus_wrapper (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .pvci_mode_in(pvci), .central_dec_in(cdec), .vci(vif.wrap),
    .m_req_out(m_req), .m_gnt_in(m_gnt), .m_valid_out(m_val), .m_addr_out(m_addr), .m_wr_out(m_wr),
    .m_wdata_out(m_wd), .m_be_out(m_be), .m_ready_in(m_rdy), .m_rdata_in(m_rd), .m_err_in(m_err),
    .s_sel_in(s_sel), .s_valid_in(s_val), .s_addr_in(s_addr), .s_wr_in(s_wr), .s_wdata_in(s_wd),
    .s_be_in(s_be), .s_ready_out(s_rdy), .s_rdata_out(s_rd));
  vobw_vc_end u_vobw_vc_end (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .pvci_mode_in(pvci), .vci(vif.vc), .req_in(req),
    .req_rd_in(req_rd), .req_addr_in(req_addr), .req_wdata_in(req_wd), .req_be_in(req_be), .busy_out(busy),
    .rsp_ready_in(rsp_rdy), .rsp_valid_out(rsp_v), .rsp_rdata_out(rsp_d), .rsp_err_out(rsp_e),
    .wr_strobe_out(wr_stb), .wr_addr_out(wr_a), .wr_data_out(wr_d));
  vobw_assertions u_vobw_assertions (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .i_cmdval(vif.i_cmdval), .i_cmdack(vif.i_cmdack),
    .i_rd(vif.i_rd), .i_addr(vif.i_addr), .i_wdata(vif.i_wdata), .i_be(vif.i_be), .i_rspval(vif.i_rspval),
    .i_rspack(vif.i_rspack), .i_rdata(vif.i_rdata), .i_rerror(vif.i_rerror), .t_cmdval(vif.t_cmdval),
    .t_cmdack(vif.t_cmdack), .t_rd(vif.t_rd), .t_addr(vif.t_addr), .t_wdata(vif.t_wdata), .t_be(vif.t_be),
    .t_rspval(vif.t_rspval), .t_rspack(vif.t_rspack), .t_rdata(vif.t_rdata));
  initial begin
    core_clk_in = 0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  task automatic finish_test();
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (vif.t_cmdval === 1'b1 && vif.t_cmdack === 1'b1) xfer_cyc <= cyc;
    if (wr_stb === 1'b1) n_wr <= n_wr + 1;
    if (cyc > 5000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // bus slave and arbiter: grant follows request, ready after rwait cycles
  always @(posedge core_clk_in) begin
    #1;
    m_gnt = m_req;
    m_rd = {m_addr[15:0], ~m_addr[15:0]};
    m_err = &m_addr[15:12];
    if (m_val === 1'b1 && m_rdy !== 1'b1 && wcnt >= rwait) begin
      m_rdy = 1;
      wcnt = 0;
      {b_addr, b_wr, b_wd, b_be} = {m_addr, m_wr, m_wd, m_be};
    end else begin
      m_rdy = 0;
      if (m_val === 1'b1) wcnt++;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic do_reset(input logic p);
    {rstn_in, pvci, hi} = {1'b0, p, HI_RST};
    tick(8);
    check("reset_outs", 32'({busy, rsp_v, s_rdy, m_req, m_val, wr_stb, vif.t_cmdval, vif.i_rspval}), 32'h0);
    rstn_in = 1;
  endtask
  task automatic t_init(input logic rd, input logic [VC_AW-1:0] a, input logic [BUS_DW-1:0] d, input int w);
    int n;
    rwait = w;
    {req, req_rd, req_addr, req_wd, req_be} = {1'b1, rd, a, d, 4'h6};
    tick(1);
    check("busy_out", 32'(busy), 32'h1);
    {req, req_addr, req_wd} = {1'b0, ~a, ~d};
    tick(6);
    rsp_rdy = 1;
    n = 0;
    while (rsp_v !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    rsp_rdy = 0;
    check("rsp_valid_out", 32'(rsp_v), 32'h1);
    check("m_addr_out", b_addr, {hi, a});
    check("m_wr_out", 32'(b_wr), {31'h0, ~rd});
    check("m_be_out", 32'(b_be), 32'h6);
    if (rd) check("rsp_rdata_out", rsp_d, {a, ~a});
    else check("m_wdata_out", b_wd, d);
    check("rsp_err_out", 32'(rsp_e), 32'(&a[15:12]));
    tick(1);
  endtask
  task automatic s_xfer(input logic wr, input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d,
                        output logic [BUS_DW-1:0] r, output int g);
    int n;
    {s_val, s_wr, s_addr, s_wd, s_be} = {1'b1, wr, a, d, 4'hf};
    n = 0;
    do begin
      tick(1);
      n++;
    end while (s_rdy !== 1'b1 && n < 200);
    r = s_rd;
    g = cyc - xfer_cyc;
    check("s_ready_out", 32'(s_rdy), 32'h1);
    tick(1);
    {s_val, s_addr, s_wd} = {1'b0, ~a, ~d};
    check("s_ready_pulse", 32'(s_rdy), 32'h0);
    tick(1);
  endtask
  task automatic t_hi();
    logic [BUS_DW-1:0] r;
    int g;
    s_xfer(1'b1, HI_ADDR, 32'hffff_1234, r, g);
    check("hi_old", r, 32'(HI_RST));
    s_xfer(1'b0, HI_ADDR, 32'h0, r, g);
    check("hi_read", r, 32'h0000_1234);
    hi = 16'h1234;
  endtask
  task automatic t_tgt(input logic [BUS_AW-1:0] base);
    logic [BUS_DW-1:0] d, r;
    int g, w0;
    for (int i = 0; i < 2; i++) begin
      d = {8'hbe, offs[i], 8'h5a, offs[i]};
      w0 = n_wr;
      s_xfer(1'b1, base | 32'(offs[i]), d, r, g);
      check("wr_strobe_out", 32'(n_wr - w0), 32'h1);
      check("cmd_to_ready", 32'(g), pvci ? 32'h2 : 32'h3);
      check("wr_addr_out", 32'(wr_a), 32'(offs[i]));
      check("wr_data_out", 32'(wr_d), 32'(offs[i][1] ? d[31:16] : d[15:0]));
      s_xfer(1'b0, base | 32'(offs[i]), 32'h0, r, g);
      check("s_rdata_out", r, offs[i][1] ? {d[31:16], 16'h0} : {16'h0, d[15:0]});
    end
  endtask
  task automatic t_ignore(input logic [BUS_AW-1:0] a);
    int seen;
    seen = 0;
    {s_val, s_wr, s_addr, s_wd, s_be} = {1'b1, 1'b1, a, 32'h0, 4'hf};
    repeat (20) begin
      tick(1);
      if (s_rdy !== 1'b0 || vif.t_cmdval !== 1'b0) seen++;
    end
    {s_val, s_addr} = {1'b0, ~a};
    tick(1);
    check("ignored", 32'(seen), 32'h0);
  endtask
  initial begin
    {rstn_in, pvci, cdec, req, req_rd, rsp_rdy, m_gnt, m_rdy, m_err, s_sel, s_val, s_wr} = '0;
    {req_addr, req_wd, req_be, m_rd, s_wd, s_be, s_addr, hi} = '0;
    {cyc, xfer_cyc, wcnt, rwait, n_wr, n_mismatch, total_checks} = '0;
    do_reset(1'b0);
    t_hi();
    t_init(1'b1, 16'h0010, 32'h0, 0);
    t_init(1'b0, 16'hf004, 32'hcafe_0123, 3);
    t_tgt(TGT_BASE);
    t_ignore(TGT_BASE | 32'h80);
    {cdec, s_sel} = 2'b11;
    t_tgt(32'h0000_0000);
    s_sel = 0;
    t_ignore(TGT_BASE);
    cdec = 0;
    do_reset(1'b1);
    t_init(1'b1, 16'h0ab0, 32'h0, 2);
    t_tgt(TGT_BASE);
    finish_test();
  end
endmodule

//--- vobw_assertions.sv
`timescale 1ns/10ps
module vobw_assertions
  import vobw_pkg::*;
(
  input wire logic              core_clk_in,
  input wire logic              rstn_in,
  input wire logic              i_cmdval,
  input wire logic              i_cmdack,
  input wire logic              i_rd,
  input wire logic [VC_AW-1:0]  i_addr,
  input wire logic [BUS_DW-1:0] i_wdata,
  input wire logic [VC_BW-1:0]  i_be,
  input wire logic              i_rspval,
  input wire logic              i_rspack,
  input wire logic [BUS_DW-1:0] i_rdata,
  input wire logic              i_rerror,
  input wire logic              t_cmdval,
  input wire logic              t_cmdack,
  input wire logic              t_rd,
  input wire logic [TGT_AW-1:0] t_addr,
  input wire logic [TGT_DW-1:0] t_wdata,
  input wire logic [TGT_BW-1:0] t_be,
  input wire logic              t_rspval,
  input wire logic              t_rspack,
  input wire logic [TGT_DW-1:0] t_rdata
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_idrop;
    !i_cmdack && !i_cmdval;
  endsequence
  sequence s_tack_next;
    !t_cmdack ##1 t_cmdack;
  endsequence
  chk_icmd_hold: assert property (i_cmdval && !i_cmdack |=> i_cmdval && $stable({i_rd, i_addr, i_wdata, i_be}))
    else $error("initiator request changed before acknowledge");
  chk_tcmd_hold: assert property (t_cmdval && !t_cmdack |=> t_cmdval && $stable({t_rd, t_addr, t_wdata, t_be}))
    else $error("target request changed before acknowledge");
  chk_irsp_hold: assert property (i_rspval && !i_rspack |=> i_rspval && $stable({i_rdata, i_rerror}))
    else $error("initiator response not held");
  chk_trsp_hold: assert property (t_rspval && !t_rspack |=> t_rspval && $stable(t_rdata))
    else $error("target response not held");
  chk_iack_pulse: assert property (i_cmdack |-> i_cmdval ##1 s_idrop)
    else $error("initiator acknowledge not a single transfer");
  chk_tack_pulse: assert property (t_cmdack |-> t_cmdval ##1 !t_cmdval)
    else $error("target acknowledge not a single transfer");
  chk_tack_delay: assert property ($rose(t_cmdval) |-> s_tack_next)
    else $error("target acknowledge timing wrong");
  chk_rsp_start: assert property ($rose(i_rspval) |-> i_cmdack)
    else $error("response raised without acknowledge");
  chk_irsp_done: assert property (i_rspval && i_rspack |=> !i_rspval)
    else $error("response not released after transfer");
endmodule

//--- vobw_bus_wrapper.sv
// Contract
// R1: initiator raises command-valid with complete request
// R2: initiator holds request until command-acknowledge sampled
// R3: peripheral read data captured at acknowledge
// R4: response held stable while response-acknowledge low
// R5: response taken when valid and acknowledge high
// R6: arbitrate, turnaround, handshake, collect bus read data
// R7: no request storage; acknowledge held off instead
// R8: buffer response while initiator cannot accept
// R9: supply upper address bits from writable register
// R10: addressed bus request raises target command-valid
// R11: command-valid from local decode or central select
// R12: target request fields stable until acknowledge
// R13: bus wait states keep bus request steady
// R14: command-valid delayed one cycle for setup
// R15: bus held until target acknowledges command
// R16: peripheral target read data captured when presented
// R17: response-acknowledge held low until bus ready
// R18: target read data registered before bus
// R19: lane multiplexing between bus and target widths
// R20: only low target address bits passed
// R21: transfer when valid and acknowledge both high
`timescale 1ns/10ps
module vobw_bus_wrapper
  import vobw_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              rstn_in,
  input  wire logic              pvci_mode_in,
  input  wire logic              central_dec_in,
  vobw_vci_if.wrap               vci,
  output logic                   m_req_out,
  input  wire logic              m_gnt_in,
  output logic                   m_valid_out,
  output logic [BUS_AW-1:0]      m_addr_out,
  output logic                   m_wr_out,
  output logic [BUS_DW-1:0]      m_wdata_out,
  output logic [VC_BW-1:0]       m_be_out,
  input  wire logic              m_ready_in,
  input  wire logic [BUS_DW-1:0] m_rdata_in,
  input  wire logic              m_err_in,
  input  wire logic              s_sel_in,
  input  wire logic              s_valid_in,
  input  wire logic [BUS_AW-1:0] s_addr_in,
  input  wire logic              s_wr_in,
  input  wire logic [BUS_DW-1:0] s_wdata_in,
  input  wire logic [VC_BW-1:0]  s_be_in,
  output logic                   s_ready_out,
  output logic [BUS_DW-1:0]      s_rdata_out
);
  vobw_ist_t         ist;
  vobw_tst_t         tst;
  logic [15:0]       addr_hi;
  logic              i_ack;
  logic              rbuf_valid;
  logic [BUS_DW:0]   rbuf_data;
  logic              t_val;
  logic              t_rd;
  logic [TGT_AW-1:0] t_addr;
  logic [TGT_DW-1:0] t_wdata;
  logic [TGT_BW-1:0] t_be;
  logic              t_rack;
  logic              t_lane;
  logic [TGT_DW-1:0] tbuf_data;

  // initiator side decode
  wire               i_start  = vci.i_cmdval & ~i_ack & ~rbuf_valid;
  wire               xfer_end = (ist == I_XFER) & m_ready_in;
  wire               rsp_take = rbuf_valid & vci.i_rspack & ~pvci_mode_in;
  wire [BUS_AW-1:0]  bus_addr = {addr_hi, vci.i_addr}; // R9

  // target side decode
  wire               hit_tgt  = s_addr_in[BUS_AW-1:WIN_LSB] == TGT_BASE[BUS_AW-1:WIN_LSB];
  wire               sel_tgt  = central_dec_in ? s_sel_in : hit_tgt; // R11
  wire               hit_hi   = s_addr_in == HI_ADDR;
  wire               s_new    = s_valid_in & ~s_ready_out & (tst == T_IDLE);
  wire               t_xfer   = (tst == T_CMD) & t_val & vci.t_cmdack; // R21
  wire               t_rxfer  = (tst == T_RSP) & vci.t_rspval & t_rack; // R21
  wire               tbuf_ld  = (t_xfer & pvci_mode_in) | t_rxfer; // R16 R18
  wire               lane_in  = s_addr_in[LANE_BIT];
  wire [TGT_DW-1:0]  lane_wd  = lane_in ? s_wdata_in[BUS_DW-1:TGT_DW] : s_wdata_in[TGT_DW-1:0]; // R19
  wire [TGT_BW-1:0]  lane_be  = lane_in ? s_be_in[VC_BW-1:TGT_BW] : s_be_in[TGT_BW-1:0]; // R19
  wire [BUS_DW-1:0]  lane_rd  = t_lane ? {tbuf_data, 16'h0000} : {16'h0000, tbuf_data}; // R19

  assign vci.i_cmdack = i_ack;
  assign vci.i_rspval = rbuf_valid & ~pvci_mode_in;
  assign vci.i_rdata  = rbuf_data[BUS_DW-1:0];
  assign vci.i_rerror = rbuf_data[BUS_DW];
  assign vci.t_cmdval = t_val;
  assign vci.t_rd     = t_rd;
  assign vci.t_addr   = t_addr;
  assign vci.t_wdata  = t_wdata;
  assign vci.t_be     = t_be;
  assign vci.t_rspack = t_rack;

  // bus response held until the initiator takes it
  vobw_hold #(
    .W (BUS_DW + 1)
  ) u_rbuf (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .load_in     (xfer_end),
    .clr_in      (rsp_take | pvci_mode_in),
    .data_in     ({m_err_in, m_rdata_in}),
    .valid_out   (rbuf_valid),
    .data_out    (rbuf_data)
  ); // R4 R8

  // target read data isolated from bus loading
  vobw_hold #(
    .W (TGT_DW)
  ) u_tbuf (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .load_in     (tbuf_ld),
    .clr_in      (1'b0),
    .data_in     (vci.t_rdata),
    .valid_out   (),
    .data_out    (tbuf_data)
  ); // R18

  // bus master path: request fields are only pipelined, never stored in the wrapper
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      m_addr_out  <= '0;
      m_wr_out    <= 1'b0;
      m_wdata_out <= '0;
      m_be_out    <= '0;
    end else begin
      m_addr_out  <= bus_addr; // R7
      m_wr_out    <= ~vci.i_rd;
      m_wdata_out <= vci.i_wdata;
      m_be_out    <= vci.i_be;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      ist         <= I_IDLE;
      m_req_out   <= 1'b0;
      m_valid_out <= 1'b0;
      i_ack       <= 1'b0;
    end else begin
      case (ist)
        I_IDLE: begin
          if (i_start) begin
            ist       <= I_REQ;
            m_req_out <= 1'b1; // R6
          end
        end
        I_REQ: begin
          if (m_gnt_in) begin
            ist <= I_TURN; // R6
          end
        end
        I_TURN: begin
          ist         <= I_XFER;
          m_valid_out <= 1'b1;
        end
        I_XFER: begin
          if (m_ready_in) begin
            ist         <= I_ACK;
            m_valid_out <= 1'b0;
            m_req_out   <= 1'b0;
            i_ack       <= 1'b1; // R7
          end
        end
        I_ACK: begin
          ist   <= I_IDLE;
          i_ack <= 1'b0;
        end
        default: begin
          ist <= I_IDLE;
        end
      endcase
    end
  end

  // bus slave path and target request presentation
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      tst         <= T_IDLE;
      addr_hi     <= HI_RST;
      t_val       <= 1'b0;
      t_rd        <= 1'b0;
      t_addr      <= '0;
      t_wdata     <= '0;
      t_be        <= '0;
      t_rack      <= 1'b0;
      t_lane      <= 1'b0;
      s_ready_out <= 1'b0;
      s_rdata_out <= '0;
    end else begin
      s_ready_out <= 1'b0;
      case (tst)
        T_IDLE: begin
          if (s_new && sel_tgt) begin
            tst     <= T_SETUP; // R10
            t_rd    <= ~s_wr_in;
            t_addr  <= s_addr_in[TGT_AW-1:0]; // R20
            t_wdata <= lane_wd;
            t_be    <= lane_be;
            t_lane  <= lane_in;
          end else if (s_new && hit_hi) begin
            if (s_wr_in) begin
              addr_hi <= s_wdata_in[15:0]; // R9
            end
            s_ready_out <= 1'b1;
            s_rdata_out <= {16'h0000, addr_hi};
          end
        end
        T_SETUP: begin
          tst   <= T_CMD;
          t_val <= 1'b1; // R14
        end
        T_CMD: begin
          if (t_xfer) begin
            t_val <= 1'b0; // R12
            if (pvci_mode_in) begin
              tst <= T_DONE;
            end else begin
              tst    <= T_RSP;
              t_rack <= 1'b1; // R17
            end
          end
        end
        T_RSP: begin
          if (t_rxfer) begin
            t_rack <= 1'b0;
            tst    <= T_DONE;
          end
        end
        T_DONE: begin
          tst         <= T_IDLE;
          s_ready_out <= 1'b1; // R13 R15
          s_rdata_out <= lane_rd;
        end
        default: begin
          tst <= T_IDLE;
        end
      endcase
    end
  end
endmodule

//--- vobw_hold.sv
`timescale 1ns/10ps
// one-entry holding register; a load wins over a clear in the same cycle
module vobw_hold #(
  parameter int unsigned W = 32
) (
  input  wire logic         core_clk_in,
  input  wire logic         rstn_in,
  input  wire logic         load_in,
  input  wire logic         clr_in,
  input  wire logic [W-1:0] data_in,
  output logic              valid_out,
  output logic [W-1:0]      data_out
);
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      valid_out <= 1'b0;
      data_out  <= '0;
    end else begin
      valid_out <= load_in | (valid_out & ~clr_in);
      if (load_in) begin
        data_out <= data_in;
      end
    end
  end
endmodule

//--- vobw_pkg.sv
package vobw_pkg;
  localparam int unsigned BUS_AW   = 32;
  localparam int unsigned BUS_DW   = 32;
  localparam int unsigned VC_AW    = 16;
  localparam int unsigned VC_BW    = 4;
  localparam int unsigned TGT_AW   = 8;
  localparam int unsigned TGT_DW   = 16;
  localparam int unsigned TGT_BW   = 2;
  localparam int unsigned TGT_WRDS = 16;
  localparam int unsigned TGT_WLSB = 1;
  localparam int unsigned LANE_BIT = 1;
  localparam int unsigned WIN_LSB  = 6;
  localparam logic [BUS_AW-1:0] TGT_BASE = 32'h4000_0000;
  localparam logic [BUS_AW-1:0] HI_ADDR  = 32'h4000_0040;
  localparam logic [15:0]       HI_RST   = 16'h0000;

  typedef enum logic [4:0] {
    I_IDLE = 5'b00001,
    I_REQ  = 5'b00010,
    I_TURN = 5'b00100,
    I_XFER = 5'b01000,
    I_ACK  = 5'b10000
  } vobw_ist_t;

  typedef enum logic [4:0] {
    T_IDLE  = 5'b00001,
    T_SETUP = 5'b00010,
    T_CMD   = 5'b00100,
    T_RSP   = 5'b01000,
    T_DONE  = 5'b10000
  } vobw_tst_t;
endpackage

//--- vobw_vc_end.sv
`timescale 1ns/10ps
module vobw_vc_end
  import vobw_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              rstn_in,
  input  wire logic              pvci_mode_in,
  vobw_vci_if.vc                 vci,
  input  wire logic              req_in,
  input  wire logic              req_rd_in,
  input  wire logic [VC_AW-1:0]  req_addr_in,
  input  wire logic [BUS_DW-1:0] req_wdata_in,
  input  wire logic [VC_BW-1:0]  req_be_in,
  output logic                   busy_out,
  input  wire logic              rsp_ready_in,
  output logic                   rsp_valid_out,
  output logic [BUS_DW-1:0]      rsp_rdata_out,
  output logic                   rsp_err_out,
  output logic                   wr_strobe_out,
  output logic [TGT_AW-1:0]      wr_addr_out,
  output logic [TGT_DW-1:0]      wr_data_out
);
  logic              c_val;
  logic              c_rd;
  logic [VC_AW-1:0]  c_addr;
  logic [BUS_DW-1:0] c_wdata;
  logic [VC_BW-1:0]  c_be;
  logic              r_ack;
  logic              t_ack;
  logic              t_rval;
  logic [TGT_DW-1:0] t_rdata;
  logic [TGT_DW-1:0] mem_word;

  wire               c_xfer  = c_val & vci.i_cmdack; // R21
  wire               r_xfer  = vci.i_rspval & r_ack & ~pvci_mode_in; // R5
  wire               p_rd    = pvci_mode_in & c_xfer & c_rd; // R3
  wire               t_xfer  = vci.t_cmdval & t_ack; // R21
  wire               t_wr    = t_xfer & ~vci.t_rd;
  wire [3:0]         widx    = vci.t_addr[TGT_WLSB+3:TGT_WLSB];

  assign vci.i_cmdval = c_val;
  assign vci.i_rd     = c_rd;
  assign vci.i_addr   = c_addr;
  assign vci.i_wdata  = c_wdata;
  assign vci.i_be     = c_be;
  assign vci.i_rspack = r_ack;
  assign vci.t_cmdack = t_ack;
  assign vci.t_rspval = t_rval;
  assign vci.t_rdata  = t_rdata;
  assign busy_out     = c_val;

  // per byte lane storage of the target
  genvar b;
  generate
    for (b = 0; b < TGT_BW; b++) begin : g_lane
      logic [7:0] lane_mem [TGT_WRDS];
      always_ff @(posedge core_clk_in) begin
        if (t_wr && vci.t_be[b]) begin
          lane_mem[widx] <= vci.t_wdata[b*8 +: 8];
        end
      end
      assign mem_word[b*8 +: 8] = lane_mem[widx];
    end
  endgenerate

  // initiator: request held until acknowledged
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      c_val         <= 1'b0;
      c_rd          <= 1'b0;
      c_addr        <= '0;
      c_wdata       <= '0;
      c_be          <= '0;
      r_ack         <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
      rsp_err_out   <= 1'b0;
    end else begin
      r_ack         <= rsp_ready_in & ~pvci_mode_in; // R4
      rsp_valid_out <= 1'b0;
      if (!c_val) begin
        if (req_in) begin
          c_val   <= 1'b1; // R1
          c_rd    <= req_rd_in;
          c_addr  <= req_addr_in;
          c_wdata <= req_wdata_in;
          c_be    <= req_be_in;
        end
      end else if (c_xfer) begin
        c_val <= 1'b0; // R2
      end
      if (p_rd || r_xfer) begin
        rsp_valid_out <= 1'b1;
        rsp_rdata_out <= vci.i_rdata;
        rsp_err_out   <= vci.i_rerror;
      end
    end
  end

  // target: ack is a one-cycle pulse in the cycle after valid rises, response held until taken
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      t_ack         <= 1'b0;
      t_rval        <= 1'b0;
      t_rdata       <= '0;
      wr_strobe_out <= 1'b0;
      wr_addr_out   <= '0;
      wr_data_out   <= '0;
    end else begin
      wr_strobe_out <= t_wr;
      if (t_wr) begin
        wr_addr_out <= vci.t_addr;
        wr_data_out <= vci.t_wdata;
      end
      if (vci.t_cmdval && !t_ack && !t_rval) begin
        t_ack   <= 1'b1;
        t_rdata <= mem_word;
      end else begin
        t_ack <= 1'b0;
      end
      if (t_xfer && !pvci_mode_in) begin
        t_rval <= 1'b1;
      end else if (t_rval && vci.t_rspack) begin
        t_rval <= 1'b0; // R4
      end
    end
  end
endmodule

//--- vobw_vci_if.sv
`timescale 1ns/10ps
interface vobw_vci_if;
  import vobw_pkg::*;
  logic                i_cmdval;
  logic                i_cmdack;
  logic                i_rd;
  logic [VC_AW-1:0]    i_addr;
  logic [BUS_DW-1:0]   i_wdata;
  logic [VC_BW-1:0]    i_be;
  logic                i_rspval;
  logic                i_rspack;
  logic [BUS_DW-1:0]   i_rdata;
  logic                i_rerror;
  logic                t_cmdval;
  logic                t_cmdack;
  logic                t_rd;
  logic [TGT_AW-1:0]   t_addr;
  logic [TGT_DW-1:0]   t_wdata;
  logic [TGT_BW-1:0]   t_be;
  logic                t_rspval;
  logic                t_rspack;
  logic [TGT_DW-1:0]   t_rdata;

  modport wrap (
    input  i_cmdval, i_rd, i_addr, i_wdata, i_be, i_rspack,
    output i_cmdack, i_rspval, i_rdata, i_rerror,
    output t_cmdval, t_rd, t_addr, t_wdata, t_be, t_rspack,
    input  t_cmdack, t_rspval, t_rdata
  );
  modport vc (
    output i_cmdval, i_rd, i_addr, i_wdata, i_be, i_rspack,
    input  i_cmdack, i_rspval, i_rdata, i_rerror,
    input  t_cmdval, t_rd, t_addr, t_wdata, t_be, t_rspack,
    output t_cmdack, t_rspval, t_rdata
  );
endinterface
